// ### design/pss_map.svh
// offsets, field positions, reset values and timing counts of the primary switch supervisor
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_ADDR_W         4
`define PSS_DATA_W         16
`define PSS_REG_CTRL       4'h0
`define PSS_REG_STATUS     4'h4
`define PSS_REG_ILIM       4'h8
`define PSS_REG_SINCE      4'hc
`define PSS_CTRL_OVP_LATCH 0
`define PSS_CTRL_TH_LATCH  1
`define PSS_CTRL_RESET     2'h0
`define PSS_ST_SEC         3
`define PSS_ST_UVB         4
`define PSS_ST_THERM       5
`define PSS_ST_SKIP        6
`define PSS_ST_BIGCAP      7
`define PSS_ST_ARSEQ       8
`define PSS_ILIM_STD       8'h80
`define PSS_ILIM_INC       8'hc0
`define PSS_PCT_FULL       100
`define PSS_PCT_FLOOR      30
`define PSS_PCT_JIT        95
`define PSS_CLK_MHZ        200
`define PSS_CLK_HZ         200000000
`define PSS_NOM_PERIOD_NS  10000
`define PSS_ILIM_K         (`PSS_NOM_PERIOD_NS * `PSS_CLK_MHZ / 1000 * `PSS_PCT_FULL)
`define PSS_RESTART_ON_MS  82
`define PSS_RESTART_ON_CYC (`PSS_RESTART_ON_MS * `PSS_CLK_MHZ * 1000)
`define PSS_AR_OFF_MS      1000
`define PSS_AR_OFF_CYC     (`PSS_AR_OFF_MS * `PSS_CLK_MHZ * 1000)
`define PSS_AR_SHORT_MS    100
`define PSS_AR_SHORT_CYC   (`PSS_AR_SHORT_MS * `PSS_CLK_MHZ * 1000)
`define PSS_ABSENCE_MS     500
`define PSS_ABSENCE_CYC    (`PSS_ABSENCE_MS * `PSS_CLK_MHZ * 1000)
`define PSS_BROWNOUT_MS    30
`define PSS_BROWNOUT_CYC   (`PSS_BROWNOUT_MS * `PSS_CLK_MHZ * 1000)
`define PSS_BLANK_NS       500
`define PSS_BLANK_CYC      (`PSS_BLANK_NS * `PSS_CLK_MHZ / 1000)
`define PSS_SKIP_CYC       (`PSS_NOM_PERIOD_NS * 5 / 2 * `PSS_CLK_MHZ / 1000)
`define PSS_NOISE_LO_US    83
`define PSS_NOISE_HI_US    142
`define PSS_NOISE_LO_CYC   (`PSS_NOISE_LO_US * `PSS_CLK_MHZ)
`define PSS_NOISE_HI_CYC   (`PSS_NOISE_HI_US * `PSS_CLK_MHZ)
`define PSS_LIGHT_US       50
`define PSS_LIGHT_CYC      (`PSS_LIGHT_US * `PSS_CLK_MHZ)
`define PSS_HS_US          30
`define PSS_HS_TOL_US      5
`define PSS_HS_LO_CYC      ((`PSS_HS_US - `PSS_HS_TOL_US) * `PSS_CLK_MHZ)
`define PSS_HS_HI_CYC      ((`PSS_HS_US + `PSS_HS_TOL_US) * `PSS_CLK_MHZ)
`define PSS_OVL_HZ         110000
`define PSS_OVL_CYC        (`PSS_CLK_HZ / `PSS_OVL_HZ)
`define PSS_SELF_US        10
`define PSS_SELF_CYC       (`PSS_SELF_US * `PSS_CLK_MHZ)
`define PSS_MAX_ON_NS      8000
`define PSS_MAX_ON_CYC     (`PSS_MAX_ON_NS * `PSS_CLK_MHZ / 1000)
`define PSS_JIT_HZ         1000
`define PSS_JIT_HALF_CYC   (`PSS_CLK_HZ / (2 * `PSS_JIT_HZ))
`define PSS_SAMPLE_US      20
`define PSS_SAMPLE_CYC     (`PSS_SAMPLE_US * `PSS_CLK_MHZ)
`define PSS_SAMPLE_LEN     16
`endif

// ### design/pss_pkg.sv
// types shared by the primary switch supervisor
package pss_pkg;
	typedef enum logic [2:0] {
		ST_CHARGE, ST_LINE_CHECK, ST_WAIT_LISTEN, ST_RUN, ST_RESTART, ST_LATCHED
	} pss_state_type;
	typedef struct packed {
		logic supply_uv;
		logic supply_shunt;
		logic supply_reset;
		logic supply_ocp;
		logic thermal_trip;
		logic thermal_cool;
		logic line_above_brownin;
		logic line_below_brownout;
		logic line_over_ov;
		logic ilim_reached;
		logic large_cap;
	} pss_sense_type;
	typedef struct packed {
		logic th_latch;
		logic ovp_latch;
	} pss_cfg_type;
endpackage

// ### design/pss_supervisor.sv
// primary switch supervisor: protection, restart, handshake and per-cycle current limit
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_supervisor
	import pss_pkg::*;
#(
	parameter int unsigned RESTART_ON_CYC = `PSS_RESTART_ON_CYC,
	parameter int unsigned AR_OFF_CYC     = `PSS_AR_OFF_CYC,
	parameter int unsigned AR_SHORT_CYC   = `PSS_AR_SHORT_CYC,
	parameter int unsigned ABSENCE_CYC    = `PSS_ABSENCE_CYC,
	parameter int unsigned BROWNOUT_CYC   = `PSS_BROWNOUT_CYC,
	parameter int unsigned SKIP_CYC       = `PSS_SKIP_CYC,
	parameter int unsigned NOISE_LO_CYC   = `PSS_NOISE_LO_CYC,
	parameter int unsigned NOISE_HI_CYC   = `PSS_NOISE_HI_CYC,
	parameter int unsigned LIGHT_CYC      = `PSS_LIGHT_CYC,
	parameter int unsigned HS_LO_CYC      = `PSS_HS_LO_CYC,
	parameter int unsigned HS_HI_CYC      = `PSS_HS_HI_CYC,
	parameter int unsigned JIT_HALF_CYC   = `PSS_JIT_HALF_CYC
) (
	// clock and reset
	input  wire logic                   core_clk_in,
	input  wire logic                   rstn_in,
	// analog comparators and straps, asynchronous
	input  wire pss_sense_type          sense_in,
	input  wire logic                   req_pulse_in,
	// register port
	input  wire logic [`PSS_ADDR_W-1:0] reg_addr_in,
	input  wire logic [`PSS_DATA_W-1:0] reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [`PSS_DATA_W-1:0] reg_rdata_out,
	// power switch control
	output logic                        switch_on_out,
	output logic                        switch_enable_out,
	output logic      [7:0]             ilim_level_out,
	output logic                        line_sense_en_out,
	output logic                        secondary_mode_out
);

	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == 32'hffffffff) ? v : v + 32'h1;
	endfunction

	function automatic logic [7:0] pct_of(input logic [7:0] v, input logic [6:0] p);
		logic [14:0] prod;
		prod = v * p;
		pct_of = 8'((prod) / 15'd100);
	endfunction

	// division is costly and evaluated every clock, but its result is taken only at cycle start
	function automatic logic [6:0] ilim_pct(input logic [31:0] el);
		logic [31:0] q;
		q = (el == 32'h0) ? 32'(`PSS_PCT_FULL) : 32'(`PSS_ILIM_K) / el;
		if (q > 32'(`PSS_PCT_FULL))
			q = 32'(`PSS_PCT_FULL);
		if (q < 32'(`PSS_PCT_FLOOR))
			q = 32'(`PSS_PCT_FLOOR);
		ilim_pct = q[6:0];
	endfunction

	pss_sense_type                   sense_meta_ff;
	pss_sense_type                   sense_ff;
	logic                            req_meta_ff;
	logic                            req_sync_ff;
	logic                            req_prev_ff;
	pss_state_type                   state_ff;
	pss_state_type                   nxt_state;
	pss_cfg_type                     cfg_ff;
	logic          [31:0]            phase_ff;
	logic          [31:0]            reqgap_ff;
	logic          [31:0]            ovl_run_ff;
	logic          [31:0]            uv_cnt_ff;
	logic          [31:0]            since_off_ff;
	logic          [31:0]            on_cnt_ff;
	logic          [31:0]            skip_ff;
	logic          [31:0]            jit_cnt_ff;
	logic          [31:0]            samp_ff;
	logic                            large_cap_ff;
	logic                            recovered_ff;
	logic                            ar_seq_ff;
	logic                            secondary_ff;
	logic                            uv_block_ff;
	logic                            th_hyst_ff;
	logic                            th_latch_ff;
	logic                            uv_arm_ff;
	logic                            switch_on_ff;
	logic                            enable_ff;
	logic                            early_ff;
	logic                            jit_low_ff;
	logic                            sense_en_ff;
	logic                            line_bi_ff;
	logic                            line_bo_ff;
	logic                            line_bo_prev_ff;
	logic                            line_ov_ff;
	logic          [7:0]             ilim_ff;
	logic          [`PSS_DATA_W-1:0] rdata_ff;

	logic req_edge;
	logic active;
	logic in_run;
	logic line_ok;
	logic line_reset;
	logic hs_hit;
	logic restart_req;
	logic latch_req;
	logic in_noise;
	logic permit;
	logic start_cycle;
	logic end_cycle;
	logic early;
	logic [6:0] pct, pct_jit;

	// first stage is read only by the second stage
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			sense_meta_ff <= '0;
			sense_ff      <= '0;
			req_meta_ff   <= 1'b0;
			req_sync_ff   <= 1'b0;
			req_prev_ff   <= 1'b0;
		end else begin
			sense_meta_ff <= sense_in;
			sense_ff      <= sense_meta_ff;
			req_meta_ff   <= req_pulse_in;
			req_sync_ff   <= req_meta_ff;
			req_prev_ff   <= req_sync_ff;
		end
	end

	assign req_edge   = req_sync_ff & ~req_prev_ff;
	assign in_run     = (state_ff == ST_RUN);
	assign active     = in_run | (state_ff == ST_WAIT_LISTEN);
	assign line_ok    = line_bi_ff & ~line_ov_ff;
	assign line_reset = line_bo_ff & ~line_bo_prev_ff;
	assign hs_hit     = active & ~secondary_ff & req_edge & (reqgap_ff >= HS_LO_CYC) & (reqgap_ff <= HS_HI_CYC);
	assign latch_req  = active & sense_ff.supply_ocp & cfg_ff.ovp_latch;
	assign restart_req = active & ((sense_ff.supply_ocp & ~cfg_ff.ovp_latch)
		| line_ov_ff
		| (uv_cnt_ff >= BROWNOUT_CYC)
		| (ovl_run_ff >= RESTART_ON_CYC)
		| (in_run & secondary_ff & (reqgap_ff >= ABSENCE_CYC))
		| (in_run & ~secondary_ff & (phase_ff >= RESTART_ON_CYC)));

	always_comb begin
		nxt_state = state_ff;
		if (sense_ff.supply_reset) begin
			nxt_state = ST_CHARGE;
		end else begin
			case (state_ff)
				ST_CHARGE: begin
					if (!sense_ff.supply_uv && sense_ff.supply_shunt)
						nxt_state = ST_LINE_CHECK;
				end
				ST_LINE_CHECK: begin
					if (line_ok)
						nxt_state = recovered_ff ? ST_WAIT_LISTEN : ST_RUN;
				end
				ST_WAIT_LISTEN: begin
					if (latch_req)
						nxt_state = ST_LATCHED;
					else if (restart_req)
						nxt_state = ST_RESTART;
					else if (hs_hit || phase_ff >= RESTART_ON_CYC)
						nxt_state = ST_RUN;
				end
				ST_RUN: begin
					if (latch_req)
						nxt_state = ST_LATCHED;
					else if (restart_req)
						nxt_state = ST_RESTART;
				end
				ST_RESTART: begin
					if (line_reset)
						nxt_state = ST_LINE_CHECK;
					else if (phase_ff >= (ar_seq_ff ? AR_OFF_CYC : AR_SHORT_CYC))
						nxt_state = ST_LINE_CHECK;
				end
				ST_LATCHED: begin
					if (line_bo_ff)
						nxt_state = ST_LINE_CHECK;
				end
				default: nxt_state = ST_CHARGE;
			endcase
		end
	end

	// every interval is a counter on the core clock
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			state_ff <= ST_CHARGE;
			phase_ff <= 32'h0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= (nxt_state != state_ff) ? 32'h0 : sat_inc(phase_ff);
		end
	end

	// strap is caught on leaving the charge phase, never at reset itself
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in)
			large_cap_ff <= 1'b0;
		else if (state_ff == ST_CHARGE && nxt_state == ST_LINE_CHECK)
			large_cap_ff <= sense_ff.large_cap;
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			recovered_ff <= 1'b0;
			ar_seq_ff    <= 1'b0;
			secondary_ff <= 1'b0;
		end else begin
			if (state_ff == ST_CHARGE)
				recovered_ff <= 1'b0;
			else if (state_ff == ST_RESTART || state_ff == ST_LATCHED)
				recovered_ff <= 1'b1;
			if (state_ff == ST_CHARGE || line_reset || hs_hit)
				ar_seq_ff <= 1'b0;
			else if (state_ff == ST_RESTART && nxt_state == ST_LINE_CHECK)
				ar_seq_ff <= 1'b1;
			if (hs_hit)
				secondary_ff <= 1'b1;
			else if (!active)
				secondary_ff <= 1'b0;
		end
	end

	// a new trip in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			uv_block_ff <= 1'b0;
			th_hyst_ff  <= 1'b0;
			th_latch_ff <= 1'b0;
		end else begin
			if (active && sense_ff.supply_uv)
				uv_block_ff <= 1'b1;
			else if (sense_ff.supply_shunt)
				uv_block_ff <= 1'b0;
			if (!cfg_ff.th_latch && sense_ff.thermal_trip)
				th_hyst_ff <= 1'b1;
			else if (sense_ff.thermal_cool)
				th_hyst_ff <= 1'b0;
			if (cfg_ff.th_latch && sense_ff.thermal_trip)
				th_latch_ff <= 1'b1;
			else if (sense_ff.supply_reset || line_bo_ff)
				th_latch_ff <= 1'b0;
		end
	end

	// line flags are only taken while the sense path is powered
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			samp_ff         <= 32'h0;
			sense_en_ff     <= 1'b1;
			line_bi_ff      <= 1'b0;
			line_bo_ff      <= 1'b0;
			line_bo_prev_ff <= 1'b0;
			line_ov_ff      <= 1'b0;
		end else begin
			samp_ff     <= (samp_ff >= 32'(`PSS_SAMPLE_CYC - 1)) ? 32'h0 : samp_ff + 32'h1;
			sense_en_ff <= (since_off_ff < LIGHT_CYC) | (samp_ff < 32'(`PSS_SAMPLE_LEN));
			line_bo_prev_ff <= line_bo_ff;
			if (sense_en_ff) begin
				line_bi_ff <= sense_ff.line_above_brownin;
				line_bo_ff <= sense_ff.line_below_brownout;
				line_ov_ff <= sense_ff.line_over_ov;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			uv_arm_ff <= 1'b0;
			uv_cnt_ff <= 32'h0;
		end else begin
			if (!active || line_bi_ff)
				uv_arm_ff <= 1'b0;
			else if (line_bo_ff)
				uv_arm_ff <= 1'b1;
			uv_cnt_ff <= (uv_arm_ff && !line_bi_ff) ? sat_inc(uv_cnt_ff) : 32'h0;
		end
	end

	// a short gap between requests keeps the overload streak alive
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			reqgap_ff  <= 32'hffffffff;
			ovl_run_ff <= 32'h0;
		end else begin
			reqgap_ff <= req_edge ? 32'h0 : sat_inc(reqgap_ff);
			if (!(in_run && secondary_ff) || reqgap_ff >= 32'(`PSS_OVL_CYC))
				ovl_run_ff <= 32'h0;
			else
				ovl_run_ff <= sat_inc(ovl_run_ff);
		end
	end

	assign in_noise = (since_off_ff >= NOISE_LO_CYC) & (since_off_ff <= NOISE_HI_CYC);
	assign permit = in_run & ~uv_block_ff & ~th_hyst_ff & ~th_latch_ff
		& (skip_ff == 32'h0) & ~sense_ff.supply_ocp;
	assign start_cycle = permit & ~switch_on_ff
		& ((secondary_ff & req_edge & ~in_noise)
		| (~secondary_ff & (since_off_ff >= 32'(`PSS_SELF_CYC))));
	assign end_cycle = switch_on_ff
		& (sense_ff.ilim_reached | (on_cnt_ff >= 32'(`PSS_MAX_ON_CYC)) | ~permit);
	assign early = sense_ff.ilim_reached & (on_cnt_ff < 32'(`PSS_BLANK_CYC));

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			switch_on_ff <= 1'b0;
			enable_ff    <= 1'b0;
			on_cnt_ff    <= 32'h0;
			since_off_ff <= 32'hffffffff;
		end else begin
			enable_ff <= permit;
			if (start_cycle) begin
				switch_on_ff <= 1'b1;
				on_cnt_ff    <= 32'h0;
			end else if (end_cycle) begin
				switch_on_ff <= 1'b0;
			end else if (switch_on_ff) begin
				on_cnt_ff <= sat_inc(on_cnt_ff);
			end
			since_off_ff <= end_cycle ? 32'h0 : sat_inc(since_off_ff);
		end
	end

	// two back-to-back early limit hits mean the transformer has not reset
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			early_ff <= 1'b0;
			skip_ff  <= 32'h0;
		end else begin
			if (end_cycle)
				early_ff <= early;
			if (end_cycle && early && early_ff)
				skip_ff <= SKIP_CYC;
			else if (skip_ff != 32'h0)
				skip_ff <= skip_ff - 32'h1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			jit_cnt_ff <= 32'h0;
			jit_low_ff <= 1'b0;
		end else if (jit_cnt_ff >= JIT_HALF_CYC - 1) begin
			jit_cnt_ff <= 32'h0;
			jit_low_ff <= ~jit_low_ff;
		end else begin
			jit_cnt_ff <= jit_cnt_ff + 32'h1;
		end
	end

	// the floor is applied again after jitter so the low half never drops under it
	assign pct_jit = 7'(pct_of({1'b0, ilim_pct(since_off_ff)}, 7'(`PSS_PCT_JIT)));
	assign pct = !jit_low_ff ? ilim_pct(since_off_ff)
		: ((pct_jit < 7'(`PSS_PCT_FLOOR)) ? 7'(`PSS_PCT_FLOOR) : pct_jit);

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in)
			ilim_ff <= `PSS_ILIM_STD;
		else if (start_cycle)
			ilim_ff <= pct_of(large_cap_ff ? `PSS_ILIM_INC : `PSS_ILIM_STD, pct);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in)
			cfg_ff <= `PSS_CTRL_RESET;
		else if (reg_wr_in && reg_addr_in == `PSS_REG_CTRL)
			cfg_ff <= reg_wdata_in[1:0];
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			rdata_ff <= '0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`PSS_REG_CTRL:   rdata_ff <= {14'h0, cfg_ff};
				`PSS_REG_STATUS: rdata_ff <= {7'h0, ar_seq_ff, large_cap_ff, (skip_ff != 32'h0),
					th_hyst_ff | th_latch_ff, uv_block_ff, secondary_ff, state_ff};
				`PSS_REG_ILIM:   rdata_ff <= {8'h0, ilim_ff};
				`PSS_REG_SINCE:  rdata_ff <= since_off_ff[15:0];
				default:         rdata_ff <= '0;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata_out      = rdata_ff;
	assign switch_on_out      = switch_on_ff;
	assign switch_enable_out  = enable_ff;
	assign ilim_level_out     = ilim_ff;
	assign line_sense_en_out  = sense_en_ff;
	assign secondary_mode_out = secondary_ff;

endmodule // pss_supervisor

// ### testbench/pss_sec_model.sv
// secondary controller model: cycle-request pulse train over the isolated link
`timescale 1ns/1ps
module pss_sec_model (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        rstn_in,
	// control from the bench
	input wire logic        en_in,
	input wire logic [15:0] period_in,
	// link
	output logic            req_pulse_out
);
	logic [15:0] cnt_ff;

	// two pulses one period apart form the handshake; a missed answer leaves the train running,
	// which the primary sees as a fresh handshake once it listens again
	always_ff @(posedge clk_in) begin
		if (!rstn_in || !en_in) begin
			cnt_ff <= 16'h0;
			req_pulse_out <= 1'b0;
		end else begin
			req_pulse_out <= (cnt_ff < 16'h3);
			cnt_ff <= (cnt_ff >= period_in - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
		end
	end
endmodule // pss_sec_model

// ### testbench/pss_supervisor_properties.sv
// concurrent checks on the ports of the primary switch supervisor
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_supervisor_properties
	import pss_pkg::*;
#(
	parameter int unsigned NOISE_LO_CYC = `PSS_NOISE_LO_CYC,
	parameter int unsigned NOISE_HI_CYC = `PSS_NOISE_HI_CYC
) (
	// clock and reset
	input wire logic          core_clk_in,
	input wire logic          rstn_in,
	// comparator inputs
	input wire pss_sense_type sense_in,
	// switch control outputs
	input wire logic          switch_on_out,
	input wire logic          switch_enable_out,
	input wire logic [7:0]    ilim_level_out,
	input wire logic          line_sense_en_out,
	input wire logic          secondary_mode_out
);
	localparam int MAX_ON = 1600;
	logic [15:0] on_cnt_ff;
	logic [15:0] off_cnt_ff;
	logic        on_seen_ff;

	// off count saturates so very light load never wraps into the band
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			on_cnt_ff <= 16'h0;
			off_cnt_ff <= 16'h0;
			on_seen_ff <= 1'b0;
		end else begin
			on_cnt_ff <= switch_on_out ? on_cnt_ff + 16'h1 : 16'h0;
			off_cnt_ff <= switch_on_out ? 16'h0 : ((&off_cnt_ff) ? off_cnt_ff : off_cnt_ff + 16'h1);
			on_seen_ff <= on_seen_ff | switch_on_out;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	AST_RESET_QUIET: assert property ($rose(rstn_in) |-> ilim_level_out == 8'h80 && !switch_enable_out && !switch_on_out)
		else $error("outputs not at reset values after reset");
	AST_ON_NEEDS_PERMIT: assert property ($rose(switch_on_out) |-> switch_enable_out)
		else $error("switch turned on without permit");
	AST_MAX_ON_TIME: assert property (on_cnt_ff <= MAX_ON + 2)
		else $error("switch on-time exceeded its maximum");
	AST_LIMIT_RANGE: assert property (ilim_level_out >= 8'h24 && ilim_level_out <= 8'hc0)
		else $error("current limit code out of range");
	AST_LIMIT_HELD: assert property (switch_on_out && $past(switch_on_out) |-> $stable(ilim_level_out))
		else $error("current limit changed within a cycle");
	AST_NOISE_BAND: assert property ($rose(switch_on_out) && secondary_mode_out && on_seen_ff
		|-> off_cnt_ff <= NOISE_LO_CYC + 2 || off_cnt_ff > NOISE_HI_CYC)
		else $error("switch turned on inside audible band");
	AST_UV_BLOCKS: assert property (sense_in.supply_uv [*6] |-> !switch_enable_out && !switch_on_out)
		else $error("switching permitted during supply undervoltage");
	AST_THERMAL_BLOCKS: assert property (sense_in.thermal_trip [*6] |-> !switch_enable_out)
		else $error("switching permitted during thermal trip");
	AST_OCP_BLOCKS: assert property (sense_in.supply_ocp [*6] |-> !switch_enable_out)
		else $error("switching permitted during shutdown current");
	AST_OV_BLOCKS: assert property ((sense_in.line_over_ov && line_sense_en_out) [*6] |-> !switch_enable_out)
		else $error("switching permitted during line overvoltage");
endmodule // pss_supervisor_properties

// ### testbench/tb_top.sv
// self-checking bench for the primary switch supervisor
`timescale 1ns/1ps
`include "pss_map.svh"
module tb_top;
	import pss_pkg::*;
	localparam int RON = 3000;
	localparam int ARSH = 600;
	localparam int AROFF = 2000;
	localparam int BRO = 500;
	logic          core_clk_in;
	logic          rstn_in;
	pss_sense_type sense_in;
	logic          req_pulse_in;
	logic [3:0]    reg_addr_in;
	logic [15:0]   reg_wdata_in;
	logic          reg_wr_in;
	logic          reg_rd_in;
	logic [15:0]   reg_rdata_out;
	logic          switch_on_out;
	logic          switch_enable_out;
	logic [7:0]    ilim_level_out;
	logic          line_sense_en_out;
	logic          secondary_mode_out;
	logic          sec_en;
	logic [15:0]   sec_period;
	logic [15:0]   st;
	int            on_n;
	int            miscompares;
	int            total_checks;

	pss_supervisor #(.RESTART_ON_CYC(RON), .AR_OFF_CYC(AROFF), .AR_SHORT_CYC(ARSH), .ABSENCE_CYC(5000),
		.BROWNOUT_CYC(BRO), .HS_LO_CYC(1900), .HS_HI_CYC(2100), .JIT_HALF_CYC(200)) u_pss_supervisor (
		.core_clk_in(core_clk_in), .rstn_in(rstn_in), .sense_in(sense_in), .req_pulse_in(req_pulse_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .switch_on_out(switch_on_out),
		.switch_enable_out(switch_enable_out), .ilim_level_out(ilim_level_out),
		.line_sense_en_out(line_sense_en_out), .secondary_mode_out(secondary_mode_out));
	pss_sec_model u_pss_sec_model (.clk_in(core_clk_in), .rstn_in(rstn_in), .en_in(sec_en),
		.period_in(sec_period), .req_pulse_out(req_pulse_in));

	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	// primary current ramps to the limit after a fixed on-time, well past the blanking window
	always @(posedge core_clk_in) begin
		on_n <= switch_on_out ? on_n + 1 : 0;
		sense_in.ilim_reached <= (on_n >= 150);
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		st = reg_rdata_out;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim, input string nm);
		int i;
		for (i = 0; i < lim; i++) begin
			rd(`PSS_REG_STATUS);
			if (st[2:0] === s) break;
		end
		chk({13'h0, st[2:0]}, {13'h0, s}, nm);
	endtask
	task automatic stbit(input int b, input logic e, input string nm);
		rd(`PSS_REG_STATUS);
		chk({15'h0, st[b]}, {15'h0, e}, nm);
	endtask
	task automatic wait_on(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && switch_on_out !== v; i++) cyc(1);
	endtask
	task automatic do_reset(input logic big);
		sense_in.large_cap <= big;
		rstn_in <= 1'b0;
		cyc(4);
		rstn_in <= 1'b1;
		cyc(1);
	endtask

	task automatic t_powerup;
		sense_in.line_above_brownin <= 1'b0;
		do_reset(1'b0);
		cyc(1500);
		wait_st(3'h1, 1, "held in line check");
		stbit(7, 1'b0, "small cap");
		sense_in.line_above_brownin <= 1'b1;
		wait_st(3'h3, 5000, "run after line ok");
		do_reset(1'b1);
		wait_st(3'h3, 5000, "run big cap");
		stbit(7, 1'b1, "big cap");
		wait_on(1'b1, 3000);
		wait_on(1'b0, 3000);
		wait_on(1'b1, 3000);
		chk({15'h0, ilim_level_out > 8'h80}, 16'h1, "raised limit");
	endtask
	task automatic t_selfrestart;
		int n;
		wait_st(3'h4, RON, "restart without requests");
		for (n = 0; n < 2000; n++) begin
			rd(`PSS_REG_STATUS);
			if (st[2:0] !== 3'h4) break;
		end
		chk({15'h0, n >= ARSH - 20 && n <= ARSH + 20}, 16'h1, "short off time");
	endtask
	task automatic t_handshake;
		int i;
		int n;
		logic prev;
		sec_en <= 1'b1;
		wait_st(3'h2, 400, "wait and listen");
		chk({15'h0, switch_on_out}, 16'h0, "quiet while listening");
		for (i = 0; i < RON + 6000 && secondary_mode_out !== 1'b1; i++) cyc(1);
		chk({15'h0, secondary_mode_out}, 16'h1, "slave after pulse pair");
		n = 0;
		for (i = 0; i < 10000; i++) begin
			prev = switch_on_out;
			cyc(1);
			if (switch_on_out === 1'b1 && prev !== 1'b1) n++;
		end
		chk({15'h0, n >= 4 && n <= 6}, 16'h1, "one cycle per request");
		chk({15'h0, line_sense_en_out}, 16'h1, "continuous line sense");
	endtask
	task automatic t_uv_therm;
		sense_in.supply_uv <= 1'b1;
		cyc(10);
		sense_in.supply_uv <= 1'b0;
		sense_in.supply_shunt <= 1'b0;
		cyc(10);
		stbit(4, 1'b1, "uv block held");
		sense_in.supply_shunt <= 1'b1;
		cyc(10);
		stbit(4, 1'b0, "uv block released");
		sense_in.thermal_trip <= 1'b1;
		cyc(10);
		sense_in.thermal_trip <= 1'b0;
		cyc(10);
		stbit(5, 1'b1, "thermal held");
		sense_in.thermal_cool <= 1'b1;
		cyc(10);
		stbit(5, 1'b0, "thermal cooled");
		wr(`PSS_REG_CTRL, 16'h2);
		sense_in.thermal_cool <= 1'b0;
		sense_in.thermal_trip <= 1'b1;
		cyc(10);
		sense_in.thermal_trip <= 1'b0;
		sense_in.thermal_cool <= 1'b1;
		cyc(10);
		stbit(5, 1'b1, "thermal latched");
		sense_in.thermal_cool <= 1'b0;
		sense_in.line_below_brownout <= 1'b1;
		cyc(10);
		sense_in.line_below_brownout <= 1'b0;
		stbit(5, 1'b0, "line reset clears latch");
		wr(`PSS_REG_CTRL, 16'h0);
	endtask
	task automatic t_overload;
		wait_st(3'h3, 8000, "run before overload");
		chk({15'h0, secondary_mode_out}, 16'h1, "slave before overload");
		sec_period <= 16'd1000;
		wait_st(3'h4, 2 * RON, "overload restart");
		sec_period <= 16'd2000;
	endtask
	task automatic t_ocp;
		sense_in.supply_ocp <= 1'b1;
		cyc(10);
		sense_in.supply_ocp <= 1'b0;
		wait_st(3'h2, 3000, "listen after restart");
		sense_in.supply_ocp <= 1'b1;
		cyc(10);
		sense_in.supply_ocp <= 1'b0;
		wait_st(3'h4, 10, "ocp auto restart");
		wr(`PSS_REG_CTRL, 16'h1);
		wait_st(3'h2, AROFF + 500, "listen before latch");
		sense_in.supply_ocp <= 1'b1;
		cyc(10);
		sense_in.supply_ocp <= 1'b0;
		wait_st(3'h5, 10, "ocp latch off");
		sense_in.supply_reset <= 1'b1;
		cyc(10);
		sense_in.supply_reset <= 1'b0;
		cyc(10);
		rd(`PSS_REG_STATUS);
		chk({15'h0, st[2:0] === 3'h5}, 16'h0, "supply reset clears latch");
		wr(`PSS_REG_CTRL, 16'h0);
	endtask
	task automatic t_line;
		wait_st(3'h3, 8000, "run before line faults");
		sense_in.line_over_ov <= 1'b1;
		wait_st(3'h4, 10, "overvoltage restart");
		sense_in.line_over_ov <= 1'b0;
		wait_st(3'h3, 8000, "resume after overvoltage");
		sense_in.line_below_brownout <= 1'b1;
		sense_in.line_above_brownin <= 1'b0;
		wait_st(3'h4, BRO + 100, "brownout restart");
		stbit(8, 1'b0, "line reset clears restart sequence");
		sense_in.line_below_brownout <= 1'b0;
		sense_in.line_above_brownin <= 1'b1;
		wait_st(3'h3, 8000, "resume after brownin");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk_in);
		miscompares++;
		end_sim;
	end

	initial begin
		rstn_in = 1'b0;
		sense_in = '0;
		sense_in.supply_shunt = 1'b1;
		sense_in.line_above_brownin = 1'b1;
		reg_addr_in = 4'h0;
		reg_wdata_in = 16'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		sec_en = 1'b0;
		sec_period = 16'd2000;
		on_n = 0;
		miscompares = 0;
		total_checks = 0;
		cyc(1);
		t_powerup;
		t_selfrestart;
		t_handshake;
		t_uv_therm;
		t_overload;
		t_ocp;
		t_line;
		end_sim;
	end
endmodule // tb_top

bind pss_supervisor pss_supervisor_properties #(.NOISE_LO_CYC(NOISE_LO_CYC), .NOISE_HI_CYC(NOISE_HI_CYC))
	u_pss_supervisor_properties (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .sense_in(sense_in),
	.switch_on_out(switch_on_out), .switch_enable_out(switch_enable_out), .ilim_level_out(ilim_level_out),
	.line_sense_en_out(line_sense_en_out), .secondary_mode_out(secondary_mode_out));
